// >>> dv/fetx_encoder_sva.sv
// Port-level assertions for the transmit encoder
`timescale 1ns/1ps
module fetx_encoder_sva #(parameter JAB_LIMIT_CYC = 1000000) (
	input wire clk_sys,
	input wire rst_n,
	input wire speed100,
	input wire xmitGateIn,
	input wire [4:0] mgmtRegAddr,
	input wire [15:0] mgmtReadData,
	input wire manchesterOut,
	input wire manchesterEnable,
	input wire normalLinkPulse,
	input wire jabberFlag,
	input wire serialBit,
	input wire serialStrobe
);
	reg [31:0] gateCnt;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	// Raw gate time runs ahead of the synced count, so it bounds the jabber moment
	always @(posedge clk_sys) gateCnt <= (!rst_n || !xmitGateIn) ? 32'h0 : gateCnt + 32'h1;
	a_drv_speed: assert property (speed100 && $past(speed100) |-> !manchesterEnable)
		else $error("driver on at 100");
	a_drv_jab: assert property (jabberFlag && $past(jabberFlag) |-> !manchesterEnable)
		else $error("driver on while jabbered");
	a_last_rise: assert property ($fell(manchesterEnable) && !jabberFlag && !speed100 |-> $past(manchesterOut))
		else $error("last half cell not high");
	a_jab_limit: assert property ($rose(jabberFlag) |-> gateCnt >= JAB_LIMIT_CYC)
		else $error("jabber too early");
	a_nlp_width: assert property ($rose(normalLinkPulse) |-> normalLinkPulse [*4] ##1 !normalLinkPulse)
		else $error("link pulse width");
	a_burst_len: assert property ($rose(serialStrobe) |-> serialStrobe [*5] ##1 !serialStrobe)
		else $error("bit burst length");
	a_nrzi_hold: assert property (!serialStrobe |-> $stable(serialBit))
		else $error("line moved off strobe");
	a_stat_addr: assert property (mgmtRegAddr != 5'h01 |=> mgmtReadData == 16'h0000)
		else $error("status off address");
	c_jab: cover property ($rose(jabberFlag));
	c_burst: cover property ($rose(serialStrobe));
	c_pulse: cover property ($rose(normalLinkPulse));
	c_man: cover property ($fell(manchesterEnable) && !jabberFlag);
endmodule // fetx_encoder_sva
bind fetx_encoder fetx_encoder_sva #(.JAB_LIMIT_CYC(JAB_LIMIT_CYC)) chk (.clk_sys, .rst_n, .speed100, .xmitGateIn,
	.mgmtRegAddr, .mgmtReadData, .manchesterOut, .manchesterEnable, .normalLinkPulse, .jabberFlag, .serialBit,
	.serialStrobe);

// >>> dv/fetx_mac_model.sv
// Behavioural MAC driving the transmit nibble interface
`timescale 1ns/1ps
module fetx_mac_model (
	output logic nibClk = 0,
	output logic gate = 0,
	output logic err = 0,
	output logic [3:0] data = 4'h0
);
	// Two preamble nibbles, n counting nibbles, then tail edges with the gate low
	task automatic frame(input int n, input logic e, input int tail);
		for (int i = 0; i < n + 2 + tail; i++) begin
			gate = i < n + 2;
			err = e && i >= 2 && gate;
			data = i < 2 ? 4'h5 : (gate ? 4'(i - 2) : ~data);
			#100 nibClk = 1;
			#100 nibClk = 0;
		end
	endtask
	// One nibble framed by the gate; the gate then drops and the data lines flip
	task automatic nibble(input logic [3:0] d);
		gate = 1;
		data = d;
		#100 nibClk = 1;
		#100 nibClk = 0;
		gate = 0;
		data = ~data;
	endtask
	// Released data lines flip so a stale value cannot pass
	task automatic quiet();
		gate = 0;
		data = ~data;
	endtask
endmodule // fetx_mac_model

// >>> dv/tb_top.sv
// Self-checking bench for the transmit encoder
`timescale 1ns/1ps
module tb_top;
	localparam [79:0] TBL = {5'h1d, 5'h1c, 5'h1b, 5'h1a, 5'h17, 5'h16, 5'h13, 5'h12, 5'h0f, 5'h0e, 5'h0b, 5'h0a,
		5'h15, 5'h14, 5'h09, 5'h1e};
	logic clk_sys = 0, rst_n = 0, speed100 = 1, rxCodeValid = 0, rxInFrame = 0, prevStrobe = 0;
	logic [4:0] phyMgmtAddress = 5'h03, mgmtRegAddr = 5'h01, rxCodeGroup = 5'h00;
	logic [31:0] sig, sigA;
	logic [4:0] seen[$];
	int fails = 0, compares = 0;
	wire nibClk, gate, err, manchesterOut, manchesterEnable, normalLinkPulse, jabberFlag, serialBit, serialStrobe, rxErr;
	wire [3:0] data, rxNibble;
	wire [4:0] codeGroup;
	wire [15:0] mgmtReadData;
	fetx_mac_model mac (.nibClk, .gate, .err, .data);
	fetx_encoder #(.NLP_PERIOD_CYC(200), .JAB_LIMIT_CYC(300), .UNJAB_CYC(400)) uut (.clk_sys, .rst_n, .speed100,
		.xmitNibbleClock(nibClk), .xmitGateIn(gate), .txErr(err), .txData(data), .phyMgmtAddress, .mgmtRegAddr,
		.mgmtReadData, .manchesterOut, .manchesterEnable, .normalLinkPulse, .jabberFlag, .codeGroup, .serialBit,
		.serialStrobe, .rxCodeValid, .rxInFrame, .rxCodeGroup, .rxNibble, .rxErr);
	initial forever #12.5 clk_sys = ~clk_sys;
	// Take each code-group as its bit burst starts; fold line bits into a signature
	always @(posedge clk_sys) begin
		prevStrobe <= serialStrobe;
		if (serialStrobe && !prevStrobe) seen.push_back(codeGroup);
		sig <= !rst_n ? 32'h0 : serialStrobe ? {sig[30:0], sig[31] ^ serialBit} : sig;
	end
	task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp) begin
			fails++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	// Reset for 12 cycles; the address is held as the scrambler seed
	task automatic rst(input logic [4:0] a);
		rst_n = 0;
		phyMgmtAddress = a;
		repeat (12) @(posedge clk_sys);
		#2 rst_n = 1;
		repeat (4) @(posedge clk_sys);
		#2;
	endtask
	// Frame of n counting nibbles, optionally errored, against the expected code-groups
	task automatic t_frame(input logic e, input int n);
		logic [4:0] ex[$];
		ex = {5'h18, 5'h11};
		for (int i = 0; i < n; i++) ex.push_back(e ? 5'h04 : TBL[i * 5 +: 5]);
		ex = {ex, 5'h0d, 5'h07, 5'h1f, 5'h1f};
		seen.delete();
		mac.frame(n, e, 4);
		repeat (20) @(posedge clk_sys);
		#2 cmp("groups", ex.size(), seen.size());
		foreach (ex[i]) cmp("group", ex[i], seen[i]);
		$display("frame test done");
	endtask
	// The same frame under another address must leave a different line pattern
	task automatic t_seed();
		rst(5'h1c);
		t_frame(0, 16);
		cmp("seed", 1, sigA !== sig);
		$display("seed test done");
	endtask
	// Bad code, data code and idle inside a frame on the receive map
	task automatic t_rx();
		logic [4:0] codes[3];
		codes = '{5'h00, 5'h1e, 5'h1f};
		for (int i = 0; i < 3; i++) begin
			rxCodeGroup = codes[i];
			rxInFrame = i[1];
			rxCodeValid = 1;
			@(posedge clk_sys) #2 rxCodeValid = 0;
			cmp("rx error", i != 1, rxErr);
			if (i < 2) cmp("rx nibble", i ? 4'h0 : 4'h6, rxNibble);
			@(posedge clk_sys) #2;
		end
		$display("rx test done");
	endtask
	// Long gate at 100 shows no jabber; at 10 it jabbers, then clears after quiet
	task automatic t_jab();
		logic seenOn;
		seenOn = 0;
		mac.frame(50, 0, 0);
		// Let the last bit burst finish before the mode changes
		repeat (8) @(posedge clk_sys);
		#2 cmp("status fast", 16'h0000, mgmtReadData);
		speed100 = 0;
		repeat (350) @(posedge clk_sys);
		#2 cmp("jabber", 1, jabberFlag);
		cmp("status", 16'h0002, mgmtReadData);
		mgmtRegAddr = 5'h02;
		@(posedge clk_sys) #2 cmp("status other", 16'h0000, mgmtReadData);
		mgmtRegAddr = 5'h01;
		// A nibble sent while jabbered must never turn the driver on
		mac.nibble(4'ha);
		repeat (20) begin
			seenOn = seenOn | manchesterEnable;
			@(posedge clk_sys) #2;
		end
		cmp("driver", 0, seenOn);
		mac.quiet();
		repeat (280) @(posedge clk_sys);
		#2 cmp("held", 1, jabberFlag);
		repeat (150) @(posedge clk_sys);
		#2 cmp("unjab", 0, jabberFlag);
		$display("jabber test done");
	endtask
	// Quiet spell between link pulses on an idle 10 Mb/s line
	task automatic t_nlp();
		int gap;
		gap = 0;
		repeat (300) if (normalLinkPulse !== 1) @(posedge clk_sys) #2;
		repeat (10) if (normalLinkPulse === 1) @(posedge clk_sys) #2;
		while (normalLinkPulse !== 1 && gap < 300) begin
			@(posedge clk_sys) #2;
			gap++;
		end
		cmp("pulse gap", 1, gap >= 195 && gap <= 201);
		$display("pulse test done");
	endtask
	// One-nibble 10 Mb/s frame: each half cell, then a closing high half cell
	task automatic t_man(input logic [3:0] d);
		logic [31:0] ex, got;
		int w;
		ex = 0;
		got = 0;
		w = 0;
		for (int k = 0; k < 4; k++) ex = {ex[27:0], ~d[k], ~d[k], d[k], d[k]};
		ex = {ex[29:0], 2'b11};
		repeat (10) @(posedge clk_sys);
		#2 mac.nibble(d);
		while (manchesterEnable !== 1 && w < 20) begin
			@(posedge clk_sys) #2;
			w++;
		end
		for (int i = 0; i < 18; i++) begin
			got = {got[30:0], manchesterOut};
			@(posedge clk_sys) #2;
		end
		cmp("manchester", ex, got);
		cmp("man end", 0, manchesterEnable);
		$display("manchester test done");
	endtask
	task automatic summarize();
		$display("counts: %0d compares, %0d fails", compares, fails);
		if (fails == 0 && compares > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	initial begin
		rst(5'h03);
		t_frame(0, 16);
		sigA = sig;
		t_frame(1, 3);
		t_seed();
		t_rx();
		t_jab();
		t_nlp();
		t_man(4'h5);
		t_man(4'ha);
		summarize();
	end
	// Cuts a hang short well past the expected run time
	initial begin
		#400000;
		fails++;
		summarize();
	end
endmodule // tb_top

// >>> logic/fetx_encoder.v
// Transmit encoder for 10 Mb/s Manchester and 100 Mb/s 4B/5B, scrambler and NRZI paths
`timescale 1ns/1ps
`include "fetx_map.vh"

// How it works
// - 10 Mb/s Manchester runs while the gate input is high and stops after the nibble in progress once it drops.
// - Last 10 Mb/s transition is positive: mid-cell for a one, cell end for zero.
// - Idle 10 Mb/s line gets a 100 ns link pulse every 16 ms.
// - Jabber cuts the 10 Mb/s output after continuous activity beyond the limit.
// - Jabber holds while transmitting and clears after about 500 ms of quiet.
// - Jabber status reads as bit 1 of the basic status register, address 1.
// - At 100 Mb/s there is no jabber and the status bit reads zero.
// - Each data nibble maps to its fixed 5-bit code-group from the table.
// - The first preamble byte becomes the J/K start pair.
// - Dropping transmit enable inserts the T/R end pair.
// - Idle code-groups follow the end pair until enable returns.
// - The error code-group is 00100.
// - Error with enable swaps data code-groups for error ones, delimiters kept.
// - Code-groups are shifted out serially, one bit at a time.
// - The serial stream is XORed with a free-running 11-bit LFSR.
// - The scrambler seed comes from the 5-bit PHY address.
// - NRZI encoding always follows the scrambler, with no bypass.
// - Undefined received code-groups become nibble 6h with receive error.
// - Idle, start and end codes inside a frame count as invalid with error.
module fetx_encoder #(
	parameter NLP_PERIOD_CYC = `FETX_NLP_PERIOD_CYC,
	parameter JAB_LIMIT_CYC = `FETX_JAB_LIMIT_CYC,
	parameter UNJAB_CYC = `FETX_UNJAB_CYC
) (
	input wire clk_sys,
	input wire rst_n,
	input wire speed100,
	input wire xmitNibbleClock,
	input wire xmitGateIn,
	input wire txErr,
	input wire [3:0] txData,
	input wire [4:0] phyMgmtAddress,
	input wire [4:0] mgmtRegAddr,
	output reg [15:0] mgmtReadData,
	output reg manchesterOut,
	output reg manchesterEnable,
	output reg normalLinkPulse,
	output reg jabberFlag,
	output reg [4:0] codeGroup,
	output reg serialBit,
	output reg serialStrobe,
	input wire rxCodeValid,
	input wire rxInFrame,
	input wire [4:0] rxCodeGroup,
	output reg [3:0] rxNibble,
	output reg rxErr
);

	localparam [1:0] ST_IDLE = 2'd0;
	localparam [1:0] ST_K = 2'd1;
	localparam [1:0] ST_DATA = 2'd2;
	localparam [1:0] ST_R = 2'd3;
	// Counts are worked out at full width, then cut on purpose to the counter widths
	localparam [31:0] HALF_CYC_W = `FETX_HALF_BIT_CYC;
	localparam [31:0] NLP_W_CYC_W = `FETX_NLP_WIDTH_CYC;
	localparam [31:0] CG_BITS_W = `FETX_CG_BITS;
	localparam [3:0] HALF_CYC = HALF_CYC_W[3:0];
	localparam [3:0] NLP_W_CYC = NLP_W_CYC_W[3:0];
	localparam [2:0] CG_BITS = CG_BITS_W[2:0];

	// 4B to 5B data code-group table
	function [4:0] enc4b5b;
		input [3:0] nib;
		begin
			case (nib)
				4'h0: enc4b5b = 5'h1e;
				4'h1: enc4b5b = 5'h09;
				4'h2: enc4b5b = 5'h14;
				4'h3: enc4b5b = 5'h15;
				4'h4: enc4b5b = 5'h0a;
				4'h5: enc4b5b = 5'h0b;
				4'h6: enc4b5b = 5'h0e;
				4'h7: enc4b5b = 5'h0f;
				4'h8: enc4b5b = 5'h12;
				4'h9: enc4b5b = 5'h13;
				4'ha: enc4b5b = 5'h16;
				4'hb: enc4b5b = 5'h17;
				4'hc: enc4b5b = 5'h1a;
				4'hd: enc4b5b = 5'h1b;
				4'he: enc4b5b = 5'h1c;
				default: enc4b5b = 5'h1d;
			endcase
		end
	endfunction

	// 5B to 4B receive map; bit 4 flags an invalid code
	function [4:0] dec5b4b;
		input [4:0] cg;
		input inFrame;
		begin
			case (cg)
				5'h1e: dec5b4b = 5'h00;
				5'h09: dec5b4b = 5'h01;
				5'h14: dec5b4b = 5'h02;
				5'h15: dec5b4b = 5'h03;
				5'h0a: dec5b4b = 5'h04;
				5'h0b: dec5b4b = 5'h05;
				5'h0e: dec5b4b = 5'h06;
				5'h0f: dec5b4b = 5'h07;
				5'h12: dec5b4b = 5'h08;
				5'h13: dec5b4b = 5'h09;
				5'h16: dec5b4b = 5'h0a;
				5'h17: dec5b4b = 5'h0b;
				5'h1a: dec5b4b = 5'h0c;
				5'h1b: dec5b4b = 5'h0d;
				5'h1c: dec5b4b = 5'h0e;
				5'h1d: dec5b4b = 5'h0f;
				`FETX_CG_IDLE, `FETX_CG_T, `FETX_CG_R:
					dec5b4b = inFrame ? {1'b1, `FETX_RX_INVALID_NIB} : 5'h00;
				`FETX_CG_J, `FETX_CG_K:
					dec5b4b = inFrame ? {1'b1, `FETX_RX_INVALID_NIB} : 5'h05;
				default: dec5b4b = {1'b1, `FETX_RX_INVALID_NIB};
			endcase
		end
	endfunction

	// Pin synchronisers; data carries one extra stage so it is read from before the clock edge
	reg nckS1, nckS2, nckS3;
	reg gateS1, gateS2, gateS3;
	reg errS1, errS2, errS3;
	reg [3:0] datS1, datS2, datS3;
	wire nibEdge = nckS2 & ~nckS3;
	always @(posedge clk_sys) begin
		if (!rst_n) begin
			nckS1 <= 1'b0;
			nckS2 <= 1'b0;
			nckS3 <= 1'b0;
			gateS1 <= 1'b0;
			gateS2 <= 1'b0;
			gateS3 <= 1'b0;
			errS1 <= 1'b0;
			errS2 <= 1'b0;
			errS3 <= 1'b0;
			datS1 <= 4'h0;
			datS2 <= 4'h0;
			datS3 <= 4'h0;
		end else begin
			nckS1 <= xmitNibbleClock;
			nckS2 <= nckS1;
			nckS3 <= nckS2;
			gateS1 <= xmitGateIn;
			gateS2 <= gateS1;
			gateS3 <= gateS2;
			errS1 <= txErr;
			errS2 <= errS1;
			errS3 <= errS2;
			datS1 <= txData;
			datS2 <= datS1;
			datS3 <= datS2;
		end
	end

	// 10 Mb/s Manchester shifter: four bits per nibble, two half cells per bit
	reg [3:0] manShift;
	reg [2:0] manBits;
	reg manHalf;
	reg [3:0] manCnt;
	reg manTail;
	wire manBusy = (manBits != 3'd0);
	wire manHalfEnd = (manCnt == HALF_CYC - 4'd1);
	always @(posedge clk_sys) begin
		if (!rst_n) begin
			manShift <= 4'h0;
			manBits <= 3'd0;
			manHalf <= 1'b0;
			manCnt <= 4'h0;
			manTail <= 1'b0;
		end else if (speed100) begin
			manBits <= 3'd0;
			manTail <= 1'b0;
			manCnt <= 4'h0;
		end else if (nibEdge && gateS3) begin
			// A new nibble restarts the cell; the MAC paces nibbles at one per four bit times
			manShift <= datS3;
			manBits <= 3'd4;
			manHalf <= 1'b0;
			manCnt <= 4'h0;
			manTail <= 1'b0;
		end else if (manBusy) begin
			manCnt <= manHalfEnd ? 4'h0 : manCnt + 4'd1;
			if (manHalfEnd) begin
				manHalf <= ~manHalf;
				if (manHalf) begin
					manShift <= {1'b0, manShift[3:1]};
					manBits <= manBits - 3'd1;
					manTail <= (manBits == 3'd1) && !gateS3;
				end
			end
		end else if (manTail) begin
			// Hold high one half cell after the frame so the last edge is a rising one
			manCnt <= manHalfEnd ? 4'h0 : manCnt + 4'd1;
			if (manHalfEnd)
				manTail <= 1'b0;
		end
	end

	// Link pulse timer runs only while the 10 Mb/s line is quiet
	reg [31:0] nlpCnt;
	wire manActive = manBusy | manTail;
	always @(posedge clk_sys) begin
		if (!rst_n || speed100 || manActive || gateS3)
			nlpCnt <= 32'h0;
		else if (nlpCnt == NLP_PERIOD_CYC - 1)
			nlpCnt <= 32'h0;
		else
			nlpCnt <= nlpCnt + 32'd1;
	end

	// Jabber watchdog: counts active time, then counts quiet time to release
	reg [31:0] jabCnt;
	always @(posedge clk_sys) begin
		if (!rst_n || speed100) begin
			jabberFlag <= 1'b0;
			jabCnt <= 32'h0;
		end else if (!jabberFlag) begin
			if (!gateS3)
				jabCnt <= 32'h0;
			else if (jabCnt >= JAB_LIMIT_CYC - 1) begin
				jabberFlag <= 1'b1;
				jabCnt <= 32'h0;
			end else
				jabCnt <= jabCnt + 32'd1;
		end else if (gateS3)
			jabCnt <= 32'h0;
		else if (jabCnt >= UNJAB_CYC - 1) begin
			jabberFlag <= 1'b0;
			jabCnt <= 32'h0;
		end else
			jabCnt <= jabCnt + 32'd1;
	end

	// 10 Mb/s line outputs; first half cell carries the inverted bit, second the bit
	always @(posedge clk_sys) begin
		if (!rst_n) begin
			manchesterOut <= 1'b0;
			manchesterEnable <= 1'b0;
			normalLinkPulse <= 1'b0;
		end else begin
			manchesterEnable <= !speed100 && manActive && !jabberFlag;
			if (manBusy)
				manchesterOut <= manHalf ? manShift[0] : ~manShift[0];
			else
				manchesterOut <= manTail;
			normalLinkPulse <= !speed100 && !jabberFlag && !manActive && !gateS3
				&& (nlpCnt >= NLP_PERIOD_CYC - NLP_W_CYC);
		end
	end

	// Status read port; the jabber bit is live only at 10 Mb/s
	always @(posedge clk_sys) begin
		if (!rst_n)
			mgmtReadData <= 16'h0000;
		else begin
			mgmtReadData <= 16'h0000;
			if (mgmtRegAddr == `FETX_BASIC_STATUS_ADDR)
				mgmtReadData[`FETX_JABBER_BIT] <= jabberFlag & ~speed100;
		end
	end

	// 100 Mb/s code-group sequencer, one code-group per nibble clock edge
	reg [1:0] cgState;
	reg [1:0] next_cgState;
	reg [4:0] next_codeGroup;
	always @* begin
		next_cgState = cgState;
		next_codeGroup = `FETX_CG_IDLE;
		case (cgState)
			ST_IDLE: begin
				if (gateS3) begin
					next_codeGroup = `FETX_CG_J;
					next_cgState = ST_K;
				end
			end
			ST_K: begin
				next_codeGroup = `FETX_CG_K;
				next_cgState = ST_DATA;
			end
			ST_DATA: begin
				if (!gateS3) begin
					next_codeGroup = `FETX_CG_T;
					next_cgState = ST_R;
				end else if (errS3)
					next_codeGroup = `FETX_CG_HALT;
				else
					next_codeGroup = enc4b5b(datS3);
			end
			ST_R: begin
				next_codeGroup = `FETX_CG_R;
				next_cgState = ST_IDLE;
			end
			default: next_cgState = ST_IDLE;
		endcase
	end

	// Serialiser, scrambler and NRZI; one code bit leaves per system clock
	reg [4:0] cgShift;
	reg [2:0] cgBits;
	reg [`FETX_LFSR_BITS-1:0] lfsr;
	reg seeded;
	wire scrBit = cgShift[4] ^ lfsr[`FETX_LFSR_BITS-1];
	always @(posedge clk_sys) begin
		if (!rst_n) begin
			cgState <= ST_IDLE;
			codeGroup <= `FETX_CG_IDLE;
			cgShift <= 5'h00;
			cgBits <= 3'd0;
			lfsr <= {`FETX_LFSR_BITS{1'b1}};
			seeded <= 1'b0;
			serialBit <= 1'b0;
			serialStrobe <= 1'b0;
		end else begin
			// Seed is caught after reset release, never as a reset value
			seeded <= 1'b1;
			if (!seeded)
				lfsr <= {1'b1, phyMgmtAddress, phyMgmtAddress};
			else
				lfsr <= {lfsr[`FETX_LFSR_BITS-2:0], lfsr[`FETX_LFSR_TAP_A] ^ lfsr[`FETX_LFSR_TAP_B]};
			serialStrobe <= 1'b0;
			if (!speed100) begin
				cgState <= ST_IDLE;
				cgBits <= 3'd0;
			end else if (nibEdge) begin
				cgState <= next_cgState;
				codeGroup <= next_codeGroup;
				cgShift <= next_codeGroup;
				cgBits <= CG_BITS;
			end else if (cgBits != 3'd0) begin
				// Leftmost code bit goes first; a one flips the line level
				cgShift <= {cgShift[3:0], 1'b0};
				cgBits <= cgBits - 3'd1;
				serialStrobe <= 1'b1;
				serialBit <= serialBit ^ scrBit;
			end
		end
	end

	// Receive-side code-group map, registered on each valid code-group
	wire [4:0] rxMap = dec5b4b(rxCodeGroup, rxInFrame);
	always @(posedge clk_sys) begin
		if (!rst_n) begin
			rxNibble <= 4'h0;
			rxErr <= 1'b0;
		end else if (rxCodeValid) begin
			rxNibble <= rxMap[3:0];
			rxErr <= rxMap[4];
		end else
			rxErr <= 1'b0;
	end

endmodule // fetx_encoder

// >>> shared/fetx_map.vh
// Constants for the fast Ethernet transmit encoder: timing, codes and status layout
`ifndef FETX_MAP_VH
`define FETX_MAP_VH

// System clock period in picoseconds (40 MHz)
`define FETX_CLK_PS 25000
// Times in their own units
`define FETX_HALF_BIT_NS 50
`define FETX_NLP_WIDTH_NS 100
`define FETX_NLP_PERIOD_MS 16
`define FETX_JAB_LIMIT_MS 25
`define FETX_UNJAB_MS 500
// Derived cycle counts
`define FETX_HALF_BIT_CYC ((`FETX_HALF_BIT_NS * 1000) / `FETX_CLK_PS)
`define FETX_NLP_WIDTH_CYC ((`FETX_NLP_WIDTH_NS * 1000 + `FETX_CLK_PS - 1) / `FETX_CLK_PS)
`define FETX_NLP_PERIOD_CYC ((`FETX_NLP_PERIOD_MS * 1000000) / (`FETX_CLK_PS / 1000))
`define FETX_JAB_LIMIT_CYC ((`FETX_JAB_LIMIT_MS * 1000000) / (`FETX_CLK_PS / 1000))
`define FETX_UNJAB_CYC ((`FETX_UNJAB_MS * 1000000) / (`FETX_CLK_PS / 1000))

// Code-group length and control code-groups
`define FETX_CG_BITS 5
`define FETX_CG_IDLE 5'h1f
`define FETX_CG_J 5'h18
`define FETX_CG_K 5'h11
`define FETX_CG_T 5'h0d
`define FETX_CG_R 5'h07
`define FETX_CG_HALT 5'h04

// Receive nibble for an undefined code-group
`define FETX_RX_INVALID_NIB 4'h6

// Basic status register address and jabber bit
`define FETX_BASIC_STATUS_ADDR 5'h01
`define FETX_JABBER_BIT 1

// Scrambler length and its feedback taps (x^11 + x^9 + 1)
`define FETX_LFSR_BITS 11
`define FETX_LFSR_TAP_A 10
`define FETX_LFSR_TAP_B 8

`endif
